// ===== verilog/port_b_pkg.sv
// Constants for the port B I/O and pin-change block
package port_b_pkg;

   // ==========================================================
   // Register indices on the plain register port
   localparam logic [3:0] OFS_PORT_B_PIN_VALUE       = 4'h0;
   localparam logic [3:0] OFS_PORT_B_DIRECTION       = 4'h1;
   localparam logic [3:0] OFS_PORT_B_PULLUP_ENABLE   = 4'h2;
   localparam logic [3:0] OFS_PORT_B_ANALOG_SELECT   = 4'h3;
   localparam logic [3:0] OFS_OPTION_SETTINGS        = 4'h4;
   localparam logic [3:0] OFS_PORT_A_PIN_CHANGE_EN   = 4'h5;
   localparam logic [3:0] OFS_PORT_B_PIN_CHANGE_EN   = 4'h6;
   localparam logic [3:0] OFS_PORT_A_ANALOG_SELECT   = 4'h7;
   localparam logic [3:0] OFS_INTERRUPT_CONTROL      = 4'h8;
   localparam logic [3:0] OFS_PORT_A_DIRECTION       = 4'h9;
   localparam logic [3:0] OFS_PORT_A_PIN_VALUE       = 4'hA;

   // ==========================================================
   // Implemented-bit masks
   localparam logic [7:0] MASK_PULLUP_B   = 8'hFE;
   localparam logic [7:0] MASK_ANALOG_B   = 8'h36;
   localparam logic [7:0] MASK_ANALOG_A   = 8'h0F;

   // ==========================================================
   // Field positions
   localparam int         POS_GLOBAL_PULLUP_ENABLE = 7;
   localparam int         POS_PIN_CHANGE_IRQ_EN    = 3;
   localparam int         POS_PIN_CHANGE_FLAG      = 0;
   localparam int         POS_PORT_A_PIN_FIVE      = 5;

   // ==========================================================
   // Values after reset
   localparam logic [7:0] RST_OUT_LATCH_B  = 8'h00;
   localparam logic [7:0] RST_DIRECTION    = 8'hFF;
   localparam logic [7:0] RST_PULLUP_B     = 8'hF6;
   localparam logic [7:0] RST_ANALOG_B     = 8'h36;
   localparam logic [7:0] RST_ANALOG_A     = 8'h0F;
   localparam logic [7:0] RST_OPTION       = 8'h00;
   localparam logic [7:0] RST_PIN_CHANGE   = 8'h00;
   localparam logic [7:0] RST_INTCTL       = 8'h00;
   localparam logic [15:0] RST_LAST_READ   = 16'h0000;

   // ==========================================================
   // Synchroniser depth
   localparam int         SYNC_STAGES = 2;

endpackage

// ===== verilog/pin_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync
   import port_b_pkg::*;
#(
   parameter int WIDTH = 16
)(
   // Clock and reset
   input  wire logic             CLK,
   input  wire logic             RESET,
   // Pin levels in and synchronised levels out
   input  wire logic [WIDTH-1:0] D,
   output logic      [WIDTH-1:0] Q
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_t;

   sync_t s;
   sync_t next_s;

   // ==========================================================
   // Stage one feeds only stage two
   always_comb begin
      next_s        = s;
      next_s.stage1 = D;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign Q = s.stage2;

endmodule

// ===== verilog/port_b_io.sv
// Port B general purpose I/O with pin-change detection for both ports
//
// Summary of operation
// R1: Port B value reads pin levels, eight bits.
// R2: Direction one is input, zero output; reset ones.
// R3: Pull-up needs global, input, bit set, digital.
// R4: Unimplemented bits read zero, ignore writes.
// R5: Analog select bits only at 5,4,2,1.
// R6: Analog pin loses input, pull-up, change detect.
// R7: Software sets direction input for analog pins.
// R8: Each pin of both ports has enable.
// R9: Power-on reset clears all pin-change enables.
// R10: Port A pin five ignored as reset pin.
// R11: Compare pin level with last-read latch.
// R12: OR of mismatches sets pin-change flag.
// R13: Flag still sets when interrupt enable clear.
// R14: Any port access reloads last-read latch.
// R15: Persisting mismatch keeps setting the flag.
// R16: Software accesses port, then clears flag.
// R17: Latch survives external-pin reset.
// R18: Change during port access may be missed.
// R19: Pin change wakes from sleep when enabled.
// R20: Pins pass two flip-flops before use.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
module port_b_io
   import port_b_pkg::*;
(
   // Clock and resets
   input  wire logic       CLK,
   input  wire logic       RESET,
   input  wire logic       EXT_RESET,
   // Configuration
   input  wire logic       RESET_PIN_SELECT,
   // Register port
   input  wire logic [3:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // Port A pin levels
   input  wire logic [7:0] PA_IN,
   // Port B pins
   input  wire logic [7:0] PB_IN,
   output logic      [7:0] PB_OUT,
   output logic      [7:0] PB_OE,
   output logic      [7:0] PB_PULLUP,
   // Pin-change requests
   output logic            IRQ_REQUEST,
   output logic            WAKE_REQUEST
);

   typedef struct packed {
      logic [7:0]  out_latch_b;
      logic [7:0]  dir_b;
      logic [7:0]  pullup_b;
      logic [7:0]  analog_b;
      logic [7:0]  option;
      logic [7:0]  change_en_a;
      logic [7:0]  change_en_b;
      logic [7:0]  analog_a;
      logic [7:0]  intctl;
      logic [7:0]  dir_a;
      logic [15:0] last_read;
      logic [7:0]  rdata;
      logic [7:0]  pb_out;
      logic [7:0]  pb_oe;
      logic [7:0]  pb_pullup;
      logic        irq;
      logic        wake;
   } state_t;

   localparam state_t RESET_STATE = '{
      out_latch_b : RST_OUT_LATCH_B,
      dir_b       : RST_DIRECTION,
      pullup_b    : RST_PULLUP_B,
      analog_b    : RST_ANALOG_B,
      option      : RST_OPTION,
      change_en_a : RST_PIN_CHANGE,
      change_en_b : RST_PIN_CHANGE,
      analog_a    : RST_ANALOG_A,
      intctl      : RST_INTCTL,
      dir_a       : RST_DIRECTION,
      last_read   : RST_LAST_READ,
      rdata       : 8'h00,
      pb_out      : RST_OUT_LATCH_B,
      pb_oe       : 8'h00,
      pb_pullup   : 8'h00,
      irq         : 1'b0,
      wake        : 1'b0
   };

   state_t s;
   state_t next_s;

   logic [15:0] pins_sync;
   logic [7:0]  digital_a;
   logic [7:0]  digital_b;
   logic [7:0]  detect_a;
   logic [7:0]  detect_b;
   logic [15:0] mismatch_bits;
   logic        mismatch;
   logic        port_access;

   // ==========================================================
   // Pin synchronisation
   pin_sync #(
      .WIDTH (16)
   ) u_pin_sync (
      .CLK   (CLK),
      .RESET (RESET),
      .D     ({PA_IN, PB_IN}),
      .Q     (pins_sync)
   ); // [R20]

   // ==========================================================
   // Digital input path and change detection
   always_comb begin
      digital_a = pins_sync[15:8] & ~(s.analog_a & MASK_ANALOG_A); // [R6]
      digital_b = pins_sync[7:0] & ~(s.analog_b & MASK_ANALOG_B); // [R6] [R1]
      detect_a  = s.change_en_a & ~(s.analog_a & MASK_ANALOG_A); // [R8] [R6]
      if (RESET_PIN_SELECT) begin
         detect_a[POS_PORT_A_PIN_FIVE] = 1'b0; // [R10]
      end
      detect_b      = s.change_en_b & ~(s.analog_b & MASK_ANALOG_B); // [R8] [R6]
      mismatch_bits = ({digital_a, digital_b} ^ s.last_read) & {detect_a, detect_b}; // [R11]
      mismatch      = |mismatch_bits; // [R12]
      port_access   = (RD || WR) &&
                      (ADDR == OFS_PORT_B_PIN_VALUE || ADDR == OFS_PORT_A_PIN_VALUE);
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;

      // Register writes
      if (WR) begin
         unique case (ADDR)
            OFS_PORT_B_PIN_VALUE:     next_s.out_latch_b = WDATA;
            OFS_PORT_B_DIRECTION:     next_s.dir_b       = WDATA; // [R2]
            OFS_PORT_B_PULLUP_ENABLE: next_s.pullup_b    = WDATA & MASK_PULLUP_B; // [R4]
            OFS_PORT_B_ANALOG_SELECT: next_s.analog_b    = WDATA & MASK_ANALOG_B; // [R5] [R4]
            OFS_OPTION_SETTINGS:      next_s.option      = WDATA;
            OFS_PORT_A_PIN_CHANGE_EN: next_s.change_en_a = WDATA; // [R8]
            OFS_PORT_B_PIN_CHANGE_EN: next_s.change_en_b = WDATA; // [R8]
            OFS_PORT_A_ANALOG_SELECT: next_s.analog_a    = WDATA & MASK_ANALOG_A;
            OFS_INTERRUPT_CONTROL:    next_s.intctl      = WDATA;
            OFS_PORT_A_DIRECTION:     next_s.dir_a       = WDATA;
            default: begin
            end
         endcase
      end

      // Mismatch sets the flag over a software clear
      if (mismatch) begin
         next_s.intctl[POS_PIN_CHANGE_FLAG] = 1'b1; // [R12] [R13] [R15] [R18]
      end

      // Port access reloads the last-read latch
      if (port_access) begin
         next_s.last_read = {digital_a, digital_b}; // [R14]
      end

      // Read data for the cycle after the strobe
      next_s.rdata = 8'h00;
      if (RD) begin
         unique case (ADDR)
            OFS_PORT_B_PIN_VALUE:     next_s.rdata = digital_b; // [R1]
            OFS_PORT_B_DIRECTION:     next_s.rdata = s.dir_b;
            OFS_PORT_B_PULLUP_ENABLE: next_s.rdata = s.pullup_b & MASK_PULLUP_B; // [R4]
            OFS_PORT_B_ANALOG_SELECT: next_s.rdata = s.analog_b & MASK_ANALOG_B; // [R4]
            OFS_OPTION_SETTINGS:      next_s.rdata = s.option;
            OFS_PORT_A_PIN_CHANGE_EN: next_s.rdata = s.change_en_a;
            OFS_PORT_B_PIN_CHANGE_EN: next_s.rdata = s.change_en_b;
            OFS_PORT_A_ANALOG_SELECT: next_s.rdata = s.analog_a & MASK_ANALOG_A;
            OFS_INTERRUPT_CONTROL:    next_s.rdata = s.intctl;
            OFS_PORT_A_DIRECTION:     next_s.rdata = s.dir_a;
            OFS_PORT_A_PIN_VALUE:     next_s.rdata = digital_a;
            default:                  next_s.rdata = 8'h00;
         endcase
      end

      // Pin drivers follow the updated control registers
      next_s.pb_out    = next_s.out_latch_b;
      next_s.pb_oe     = ~next_s.dir_b; // [R2]
      next_s.pb_pullup = {8{next_s.option[POS_GLOBAL_PULLUP_ENABLE]}} &
                         next_s.dir_b & next_s.pullup_b & MASK_PULLUP_B &
                         ~(next_s.analog_b & MASK_ANALOG_B); // [R3] [R6]

      // Requests gated by the pin-change interrupt enable
      next_s.irq  = next_s.intctl[POS_PIN_CHANGE_FLAG] &
                    next_s.intctl[POS_PIN_CHANGE_IRQ_EN]; // [R13]
      next_s.wake = next_s.intctl[POS_PIN_CHANGE_FLAG] &
                    next_s.intctl[POS_PIN_CHANGE_IRQ_EN]; // [R19]
   end

   // ==========================================================
   // State register
   always_ff @(posedge CLK) begin
      if (RESET) begin
         s <= RESET_STATE; // [R9]
      end else if (EXT_RESET) begin
         s           <= RESET_STATE; // [R9]
         s.last_read <= s.last_read; // [R17]
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign RDATA        = s.rdata;
   assign PB_OUT       = s.pb_out;
   assign PB_OE        = s.pb_oe;
   assign PB_PULLUP    = s.pb_pullup;
   assign IRQ_REQUEST  = s.irq;
   assign WAKE_REQUEST = s.wake;

endmodule

// ===== test/port_b_io_chk.sv
// Checker on the port B I/O block ports
`timescale 1ns/1ps
module port_b_io_chk
   import port_b_pkg::*;
(
   // Clock and resets
   input wire logic       CLK,
   input wire logic       RESET,
   input wire logic       EXT_RESET,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   // Pins and requests
   input wire logic [7:0] PB_OUT,
   input wire logic [7:0] PB_OE,
   input wire logic [7:0] PB_PULLUP,
   input wire logic       IRQ_REQUEST,
   input wire logic       WAKE_REQUEST
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET || EXT_RESET);
   a_dir_to_oe: assert property (
      WR && ADDR == OFS_PORT_B_DIRECTION |=> PB_OE == ~$past(WDATA))
      else $error("Enable not from direction");
   a_reset_inputs: assert property (
      disable iff (1'b0) RESET |=> PB_OE == 8'h00 && !IRQ_REQUEST)
      else $error("Reset state wrong");
   a_pullup_input: assert property (
      (PB_PULLUP & PB_OE) == 8'h00) else $error("Pull-up on driven pin");
   a_pullup_bit0: assert property (
      !PB_PULLUP[0]) else $error("Pull-up on missing bit");
   a_unmapped_zero: assert property (
      RD && ADDR > OFS_PORT_A_PIN_VALUE |=> RDATA == 8'h00) else $error("Unmapped read");
   a_wake_irq: assert property (
      WAKE_REQUEST == IRQ_REQUEST) else $error("Wake differs from request");
   a_irq_needs_en: assert property (
      WR && ADDR == OFS_INTERRUPT_CONTROL && !WDATA[POS_PIN_CHANGE_IRQ_EN] |=> !IRQ_REQUEST)
      else $error("Request without enable");
   a_out_latch: assert property (
      WR && ADDR == OFS_PORT_B_PIN_VALUE |=> PB_OUT == $past(WDATA))
      else $error("Output latch not written");
   a_irq_from_flag: assert property (
      RD && ADDR == OFS_INTERRUPT_CONTROL |=>
      $past(IRQ_REQUEST) == (RDATA[POS_PIN_CHANGE_FLAG] && RDATA[POS_PIN_CHANGE_IRQ_EN]))
      else $error("Request differs from flag and enable");
endmodule
bind port_b_io port_b_io_chk chk (
   .CLK          (CLK),
   .RESET        (RESET),
   .EXT_RESET    (EXT_RESET),
   .ADDR         (ADDR),
   .WDATA        (WDATA),
   .WR           (WR),
   .RD           (RD),
   .RDATA        (RDATA),
   .PB_OUT       (PB_OUT),
   .PB_OE        (PB_OE),
   .PB_PULLUP    (PB_PULLUP),
   .IRQ_REQUEST  (IRQ_REQUEST),
   .WAKE_REQUEST (WAKE_REQUEST)
);

// ===== test/pin_world.sv
// Outside circuitry on the port B pins
`timescale 1ns/1ps
module pin_world (
   // Device drive
   input  wire logic [7:0] drive_en,
   input  wire logic [7:0] drive_val,
   // Outside source
   input  wire logic [7:0] src,
   output      logic [7:0] pin
);
   // Released pins follow the outside source
   assign pin = (drive_en & drive_val) | (~drive_en & src);
endmodule

// ===== test/testbench.sv
// Self-checking bench for the port B I/O block
`timescale 1ns/1ps
module testbench;
   import port_b_pkg::*;
   // ==========================================================
   // Signals and model state
   logic        clk, reset, ext_reset, pin_sel, wstb, rstb, irq, wake;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, pa, src, pin_b, pb_o, pb_oe, pb_pu;
   logic [7:0]  m [16];
   logic [15:0] last;
   logic [31:0] seed;
   int          failures, n_checks, cyc;
   port_b_io uut (.CLK(clk), .RESET(reset), .EXT_RESET(ext_reset), .RESET_PIN_SELECT(pin_sel),
      .ADDR(addr), .WDATA(wdata), .WR(wstb), .RD(rstb), .RDATA(rdata), .PA_IN(pa),
      .PB_IN(pin_b), .PB_OUT(pb_o), .PB_OE(pb_oe), .PB_PULLUP(pb_pu), .IRQ_REQUEST(irq),
      .WAKE_REQUEST(wake));
   pin_world far (.drive_en(pb_oe), .drive_val(pb_o), .src(src), .pin(pin_b));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [7:0] wmask(input int a);
      if (a == 2) return 8'hFE;
      if (a == 3) return 8'h36;
      if (a == 7) return 8'h0F;
      return (a < 10) ? 8'hFF : 8'h00;
   endfunction
   function automatic logic [15:0] levels();
      return {pa & ~m[7], ((~m[1] & m[0]) | (m[1] & src)) & ~m[3]};
   endfunction
   function automatic logic mism();
      return |((levels() ^ last) & {m[5] & ~{2'b00, pin_sel, 5'b0_0000}, m[6]});
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic model_reset(input logic por);
      m = '{default: 8'h00};
      m[1] = 8'hFF;
      m[9] = 8'hFF;
      m[2] = 8'hF6;
      m[3] = 8'h36;
      m[7] = 8'h0F;
      if (por) last = '0;
   endtask
   task automatic wr(input int a, input logic [7:0] d);
      @(posedge clk);
      addr <= a[3:0];
      wdata <= d;
      wstb <= 1'b1;
      @(posedge clk);
      wstb <= 1'b0;
      m[a] = (d & wmask(a)) | {7'b0, a == 8 && mism()};
      if (a == 0 || a == 10) last = levels();
   endtask
   task automatic rd(input int a, input logic [7:0] mk);
      logic [15:0] lv;
      @(posedge clk);
      addr <= a[3:0];
      rstb <= 1'b1;
      @(posedge clk);
      rstb <= 1'b0;
      lv = levels();
      #1 cmp(rdata & mk, (a == 0 ? lv[7:0] : a == 10 ? lv[15:8] : m[a]) & mk);
      if (a == 0 || a == 10) last = lv;
   endtask
   task automatic chk_out();
      #1 cmp(pb_oe, ~m[1]);
      cmp(pb_o, m[0]);
      cmp(pb_pu, m[4][7] ? m[1] & m[2] & ~m[3] : 8'h00);
      cmp({6'b0, wake, irq}, {6'b0, {2{m[8][0] & m[8][3]}}});
   endtask
   task automatic toggle(input int i);
      @(posedge clk);
      {pa, src} <= {pa, src} ^ (16'h0001 << i);
      repeat (4) @(posedge clk);
      if (mism()) m[8][0] = 1'b1;
   endtask
   task automatic pulse(input logic por);
      @(posedge clk);
      if (por) reset <= 1'b1;
      else ext_reset <= 1'b1;
      @(posedge clk);
      {reset, ext_reset} <= 2'b00;
      model_reset(por);
      repeat (4) @(posedge clk);
   endtask
   task automatic give_verdict();
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         give_verdict();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      {ext_reset, pin_sel, wstb, rstb, addr, wdata} = '0;
      reset = 1'b1;
      seed = 32'h0000_8EC0;
      pa = 8'h5A;
      src = 8'hC3;
      model_reset(1'b1);
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 16; i++) rd(i, 8'hFF);
      for (int i = 0; i < 48; i++) begin
         @(posedge clk);
         seed = xs(seed);
         pa <= seed[23:16];
         src <= seed[31:24];
         wr(seed[11:8], seed[7:0] & (seed[11:8] == 4'h8 ? 8'hF6 : 8'hFF));
      end
      repeat (4) @(posedge clk);
      chk_out();
      for (int i = 0; i < 16; i++) rd(i, i == 8 ? 8'hFE : 8'hFF);
      pulse(1'b1);
      wr(3, 8'h00);
      wr(7, 8'h00);
      wr(4, 8'h80);
      wr(5, 8'hFF);
      wr(6, 8'hFF);
      rd(0, 8'hFF);
      wr(8, 8'h08);
      for (int i = 0; i < 16; i++) begin
         toggle(i);
         rd(8, 8'hFF);
         chk_out();
         wr(8, 8'h08);
         rd(8, 8'hFF);
         rd(i < 8 ? 0 : 10, 8'hFF);
         wr(8, 8'h08);
         rd(8, 8'hFF);
      end
      wr(8, 8'h00);
      toggle(3);
      chk_out();
      rd(8, 8'hFF);
      rd(0, 8'hFF);
      wr(8, 8'h08);
      pin_sel <= 1'b1;
      toggle(13);
      rd(8, 8'hFF);
      rd(10, 8'hFF);
      wr(3, 8'h02);
      pin_sel <= 1'b0;
      rd(0, 8'hFF);
      toggle(1);
      rd(8, 8'hFF);
      chk_out();
      toggle(0);
      pulse(1'b0);
      wr(3, 8'h00);
      wr(7, 8'h00);
      wr(6, 8'hFF);
      wr(8, 8'h00);
      rd(8, 8'hFF);
      give_verdict();
   end
endmodule
